// *** include/ddr2_cmd_regs.vh ***
// Constants for the DDR2 command decoder and bank state checker
`ifndef DDR2_CMD_REGS_VH
`define DDR2_CMD_REGS_VH
`define NUM_BANKS 8
`define BANK_W 3
`define ADDR_W 15
`define AP_BIT 10
`define CMD_W 4
// Command strobe pattern {cs_n, ras_n, cas_n, we_n}
`define PAT_MRS 4'h0
`define PAT_REF 4'h1
`define PAT_PRE 4'h2
`define PAT_ACT 4'h3
`define PAT_WR 4'h4
`define PAT_RD 4'h5
`define PAT_NOP 4'h7
// Decoded command codes
`define CMD_NONE 4'h0
`define CMD_MRS 4'h1
`define CMD_REF 4'h2
`define CMD_SRE 4'h3
`define CMD_SRX 4'h4
`define CMD_PRE 4'h5
`define CMD_PREA 4'h6
`define CMD_ACT 4'h7
`define CMD_WR 4'h8
`define CMD_WRA 4'h9
`define CMD_RD 4'ha
`define CMD_RDA 4'hb
`define CMD_NOP 4'hc
`define CMD_DES 4'hd
`define CMD_PDE 4'he
`define CMD_PDX 4'hf
// Timing in ns (tMRD and burst in clocks) and clock period in ns
`define CLK_NS 10
`define TRCD_NS 15
`define TRP_NS 15
`define TRFC_NS 195
`define TXSNR_NS 205
`define TMRD_CK 5'h02
`define BURST_CK 5'h02
`define TIMER_W 5
`endif

// *** hdl/ddr2_bank_tracker.v ***
// One bank's state tracker with acceptance check
`default_nettype none
`include "ddr2_cmd_regs.vh"
module ddr2_bank_tracker (
    input wire i_clk_sys,
    input wire i_arst_n,
    input wire i_valid,
    input wire [3:0] i_cmd,
    input wire i_hit,
    output reg [5:0] o_state,
    output reg o_illegal
);
    localparam [5:0] ST_IDLE = 6'h01;
    localparam [5:0] ST_ACTIVATING = 6'h02;
    localparam [5:0] ST_ACTIVE = 6'h04;
    localparam [5:0] ST_READ = 6'h08;
    localparam [5:0] ST_WRITE = 6'h10;
    localparam [5:0] ST_PRECHARGING = 6'h20;
    localparam integer TRCD_WAIT = (`TRCD_NS + `CLK_NS - 1) / `CLK_NS;
    localparam integer TRP_WAIT = (`TRP_NS + `CLK_NS - 1) / `CLK_NS;
    // Rounded up to whole cycles, then cut to the timer width on purpose
    localparam [4:0] TRCD_CK = TRCD_WAIT[4:0];
    localparam [4:0] TRP_CK = TRP_WAIT[4:0];
    localparam [4:0] BURST_CK = `BURST_CK;
    reg [4:0] timer;
    reg [5:0] next_state;
    reg [4:0] next_timer;
    reg next_illegal;
    wire is_pre = (i_cmd == `CMD_PREA) || ((i_cmd == `CMD_PRE) && i_hit);
    wire is_rd = i_hit && ((i_cmd == `CMD_RD) || (i_cmd == `CMD_RDA));
    wire is_wr = i_hit && ((i_cmd == `CMD_WR) || (i_cmd == `CMD_WRA));
    wire is_ap = i_hit && ((i_cmd == `CMD_RDA) || (i_cmd == `CMD_WRA));
    wire is_act = i_hit && (i_cmd == `CMD_ACT);
    wire is_all = (i_cmd == `CMD_REF) || (i_cmd == `CMD_MRS);
    wire touches = is_pre || is_rd || is_wr || is_act || is_all;
    always @* begin
        next_state = o_state;
        next_timer = (timer != 5'h00) ? timer - 5'h01 : timer;
        next_illegal = 1'b0;
        case (o_state)
            ST_IDLE: begin
                if (is_act) begin
                    next_state = ST_ACTIVATING;
                    next_timer = TRCD_CK - 5'h01;
                end else if (is_all) begin
                    next_state = ST_IDLE;
                end else if (i_valid && touches && !is_pre) begin
                    next_illegal = 1'b1;
                end
            end
            ST_ACTIVATING, ST_PRECHARGING: begin
                if (timer == 5'h00) begin
                    next_state = (o_state == ST_ACTIVATING) ? ST_ACTIVE : ST_IDLE;
                end
                if (i_valid && touches && !(is_pre && i_cmd == `CMD_PREA)) begin
                    next_illegal = 1'b1;
                end
            end
            ST_ACTIVE, ST_READ, ST_WRITE: begin
                if (o_state != ST_ACTIVE && timer == 5'h00) begin
                    next_state = ST_ACTIVE;
                end
                if (is_pre) begin
                    next_state = ST_PRECHARGING;
                    next_timer = TRP_CK - 5'h01;
                end else if (is_rd || is_wr) begin
                    // Auto precharge: burst then tRP folded into one wait
                    next_state = is_ap ? ST_PRECHARGING : (is_rd ? ST_READ : ST_WRITE);
                    next_timer = is_ap ? BURST_CK + TRP_CK - 5'h01 : BURST_CK - 5'h01;
                end else if (i_valid && (is_act || is_all)) begin
                    next_illegal = 1'b1;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (!i_valid) begin
            next_state = (timer == 5'h00 && o_state != ST_IDLE && o_state != ST_ACTIVE) ?
                ((o_state == ST_ACTIVATING) || (o_state == ST_READ) || (o_state == ST_WRITE) ?
                ST_ACTIVE : ST_IDLE) : o_state;
            next_timer = (timer != 5'h00) ? timer - 5'h01 : timer;
            next_illegal = 1'b0;
        end
    end
    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_state <= ST_IDLE;
            timer <= 5'h00;
            o_illegal <= 1'b0;
        end else begin
            o_state <= next_state;
            timer <= next_timer;
            o_illegal <= next_illegal;
        end
    end
endmodule
`default_nettype wire

// *** hdl/ddr2_command_decode_bank_state.v ***
// DDR2 command decoder with per-bank state checking
`default_nettype none
`include "ddr2_cmd_regs.vh"
module ddr2_command_decode_bank_state (
    input wire i_clk_sys,
    input wire i_arst_n,
    input wire i_cke,
    input wire i_cs_n,
    input wire i_ras_n,
    input wire i_cas_n,
    input wire i_we_n,
    input wire [2:0] i_ba,
    input wire [14:0] i_addr,
    input wire i_odt,
    input wire i_ba2_used,
    output reg [3:0] o_cmd,
    output reg o_cmd_valid,
    output reg [2:0] o_bank,
    output reg [14:0] o_addr,
    output reg o_auto_pre,
    output reg o_power_down,
    output reg o_self_refresh,
    output reg o_odt_enable,
    output reg o_illegal,
    output reg [7:0] o_bank_idle,
    output reg [7:0] o_bank_active
);
    localparam integer TRFC_WAIT = (`TRFC_NS + `CLK_NS - 1) / `CLK_NS;
    localparam integer TXSNR_WAIT = (`TXSNR_NS + `CLK_NS - 1) / `CLK_NS;
    // Rounded up to whole cycles, then cut to the timer width on purpose
    localparam [4:0] TRFC_CK = TRFC_WAIT[4:0];
    localparam [4:0] TXSNR_CK = TXSNR_WAIT[4:0];
    localparam [4:0] TMRD_CK = `TMRD_CK;
    localparam [2:0] PM_NORMAL = 3'h1;
    localparam [2:0] PM_POWER_DOWN = 3'h2;
    localparam [2:0] PM_SELF_REFRESH = 3'h4;
    // Pins cross from the pad domain through two flops
    reg [23:0] pin_meta;
    reg [23:0] pin_sync;
    // Density strap is a pin too, so it gets the same two flops
    reg strap_meta;
    reg strap_sync;
    reg cmd_illegal;
    reg cke_prev;
    reg [2:0] pmode;
    reg [4:0] gate_timer;
    reg [3:0] next_cmd;
    reg [2:0] next_pmode;
    reg [4:0] next_gate_timer;
    wire cke = pin_sync[23];
    wire [3:0] pat = pin_sync[22:19];
    wire [2:0] ba_raw = pin_sync[18:16];
    wire [14:0] addr = pin_sync[15:1];
    wire odt = pin_sync[0];
    wire ba2_used = strap_sync;
    wire [2:0] ba = {ba_raw[2] & ba2_used, ba_raw[1:0]};
    wire nop_like = pat[3] || (pat == `PAT_NOP);
    wire steady = cke_prev && cke && (gate_timer == 5'h00);
    wire [47:0] states;
    wire [7:0] illegal_bits;
    wire [7:0] hits;
    wire all_idle;

    function [3:0] decode;
        input prev;
        input cur;
        input [3:0] p;
        input ap;
        input nl;
        begin
            decode = `CMD_NONE;
            if (!prev && cur && nl) begin
                decode = `CMD_PDX;
            end else if (prev && !cur) begin
                decode = (p == `PAT_REF) ? `CMD_SRE : (nl ? `CMD_PDE : `CMD_NONE);
            end else if (prev && cur) begin
                if (p[3]) begin
                    decode = `CMD_DES;
                end else begin
                    case (p)
                        `PAT_MRS: decode = `CMD_MRS;
                        `PAT_REF: decode = `CMD_REF;
                        `PAT_PRE: decode = ap ? `CMD_PREA : `CMD_PRE;
                        `PAT_ACT: decode = `CMD_ACT;
                        `PAT_WR: decode = ap ? `CMD_WRA : `CMD_WR;
                        `PAT_RD: decode = ap ? `CMD_RDA : `CMD_RD;
                        `PAT_NOP: decode = `CMD_NOP;
                        default: decode = `CMD_NONE;
                    endcase
                end
            end
        end
    endfunction

    always @* begin
        next_cmd = decode(cke_prev, cke, pat, addr[`AP_BIT], nop_like);
        next_pmode = pmode;
        next_gate_timer = (gate_timer != 5'h00) ? gate_timer - 5'h01 : gate_timer;
        case (pmode)
            PM_NORMAL: begin
                if (next_cmd == `CMD_SRE) begin
                    next_pmode = PM_SELF_REFRESH;
                end else if (next_cmd == `CMD_PDE) begin
                    next_pmode = PM_POWER_DOWN;
                end else if (next_cmd == `CMD_REF) begin
                    next_gate_timer = TRFC_CK - 5'h01;
                end else if (next_cmd == `CMD_MRS) begin
                    next_gate_timer = TMRD_CK - 5'h01;
                end
            end
            PM_POWER_DOWN: begin
                if (next_cmd == `CMD_PDX) begin
                    next_pmode = PM_NORMAL;
                end
            end
            PM_SELF_REFRESH: begin
                // Exit needs a high clock enable together with NOP or deselect on the strobes
                if (cke && nop_like) begin
                    next_pmode = PM_NORMAL;
                    next_gate_timer = TXSNR_CK;
                    next_cmd = `CMD_SRX;
                end else begin
                    next_cmd = `CMD_NONE;
                end
            end
            default: begin
                next_pmode = PM_NORMAL;
            end
        endcase
    end

    genvar g;
    generate
        for (g = 0; g < `NUM_BANKS; g = g + 1) begin : banks
            assign hits[g] = (ba == g);
            ddr2_bank_tracker u_bank (
                .i_clk_sys(i_clk_sys),
                .i_arst_n(i_arst_n),
                .i_valid(steady && (pmode == PM_NORMAL) && !nop_like),
                .i_cmd(next_cmd),
                .i_hit(hits[g]),
                .o_state(states[g*6 +: 6]),
                .o_illegal(illegal_bits[g])
            );
        end
    endgenerate

    assign all_idle = &{states[0], states[6], states[12], states[18],
                        states[24], states[30], states[36], states[42]};

    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pin_meta <= 24'h000000;
            pin_sync <= 24'h000000;
            strap_meta <= 1'b0;
            strap_sync <= 1'b0;
            cmd_illegal <= 1'b0;
            cke_prev <= 1'b0;
            pmode <= PM_NORMAL;
            gate_timer <= 5'h00;
            o_cmd <= `CMD_NONE;
            o_cmd_valid <= 1'b0;
            o_bank <= 3'h0;
            o_addr <= 15'h0000;
            o_auto_pre <= 1'b0;
            o_power_down <= 1'b0;
            o_self_refresh <= 1'b0;
            o_odt_enable <= 1'b0;
            o_illegal <= 1'b0;
            o_bank_idle <= 8'hff;
            o_bank_active <= 8'h00;
        end else begin
            pin_meta <= {i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n, i_ba, i_addr, i_odt};
            pin_sync <= pin_meta;
            strap_meta <= i_ba2_used;
            strap_sync <= strap_meta;
            cke_prev <= cke;
            pmode <= next_pmode;
            gate_timer <= next_gate_timer;
            o_cmd <= next_cmd;
            o_cmd_valid <= (next_cmd != `CMD_NONE);
            o_bank <= ba;
            o_addr <= addr;
            o_auto_pre <= addr[`AP_BIT];
            o_power_down <= (next_pmode == PM_POWER_DOWN);
            o_self_refresh <= (next_pmode == PM_SELF_REFRESH);
            // Termination never alters decode, and is cut in self refresh
            o_odt_enable <= odt && (next_pmode != PM_SELF_REFRESH);
            cmd_illegal <= (steady && !all_idle && ((next_cmd == `CMD_REF) || (next_cmd == `CMD_MRS))) ||
                (!nop_like && cke && (gate_timer != 5'h00) && (pmode == PM_NORMAL));
            // Bank flags come a cycle after the command, so these terms wait one too
            o_illegal <= (|illegal_bits) || cmd_illegal;
            o_bank_idle <= {states[42], states[36], states[30], states[24],
                            states[18], states[12], states[6], states[0]};
            o_bank_active <= {states[44], states[38], states[32], states[26],
                              states[20], states[14], states[8], states[2]};
        end
    end
endmodule
`default_nettype wire

// *** testbench/ddr2_decode_props.sv ***
// Assertions on command decode and bank state of the DDR2 decoder
`default_nettype none
`include "ddr2_cmd_regs.vh"
module ddr2_decode_props (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_cke,
    input wire logic i_cs_n,
    input wire logic i_ras_n,
    input wire logic i_cas_n,
    input wire logic i_we_n,
    input wire logic [14:0] i_addr,
    input wire logic [3:0] o_cmd,
    input wire logic [2:0] o_bank,
    input wire logic o_auto_pre,
    input wire logic o_illegal,
    input wire logic [7:0] o_bank_idle,
    input wire logic [7:0] o_bank_active
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] up_cnt;
    logic [3:0] pat;
    logic ready;
    // Sync flops still hold reset values for a few edges after release
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n)
            up_cnt <= 3'h0;
        else if (up_cnt != 3'h7)
            up_cnt <= up_cnt + 3'h1;
    end
    assign pat = {i_cs_n, i_ras_n, i_cas_n, i_we_n};
    assign ready = (up_cnt == 3'h7);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);
    sequence steady_high;
        ready && $past(i_cke) && i_cke;
    endsequence
    sequence act_taken;
        ready && o_cmd == `CMD_ACT && o_bank_idle[o_bank] ##1 !o_illegal;
    endsequence
    a_act_decode: assert property (steady_high ##0 pat == `PAT_ACT |-> ##3 o_cmd == `CMD_ACT)
        else $error("activate not decoded");
    a_mode_load: assert property (steady_high ##0 pat == `PAT_MRS |-> ##3 o_cmd == `CMD_MRS)
        else $error("mode load not decoded");
    a_refresh_decode: assert property (steady_high ##0 pat == `PAT_REF |-> ##3 o_cmd == `CMD_REF)
        else $error("refresh not decoded");
    a_self_ref_entry: assert property (ready && $past(i_cke) && !i_cke && pat == `PAT_REF
        |-> ##3 o_cmd == `CMD_SRE)
        else $error("self refresh entry not decoded");
    a_pd_entry: assert property (ready && $past(i_cke) && !i_cke && (i_cs_n || pat == `PAT_NOP)
        |-> ##3 o_cmd == `CMD_PDE)
        else $error("power-down entry not decoded");
    a_pre_all: assert property (steady_high ##0 pat == `PAT_PRE && i_addr[10] |-> ##3 o_cmd == `CMD_PREA)
        else $error("precharge all not decoded");
    a_read_ap: assert property (steady_high ##0 pat == `PAT_RD |-> ##3 o_auto_pre == $past(i_addr[10], 3))
        else $error("auto precharge flag wrong");
    a_deselect: assert property (steady_high ##0 i_cs_n |-> ##3 o_cmd == `CMD_DES)
        else $error("deselect not decoded");
    a_idle_read: assert property (ready && o_cmd == `CMD_RD && o_bank_idle[o_bank] |-> ##1 o_illegal)
        else $error("read to idle bank not flagged");
    a_act_opens: assert property (act_taken |-> ##2 o_bank_active[$past(o_bank, 3)])
        else $error("activated bank not active in time");
endmodule
bind ddr2_command_decode_bank_state ddr2_decode_props props_u (.*);
`default_nettype wire

// *** testbench/ddr2_ctrl_model.sv ***
// Controller model driving command and address pins
`default_nettype none
`include "ddr2_cmd_regs.vh"
module ddr2_ctrl_model (
    input wire logic i_clk_sys,
    output logic o_cke,
    output logic o_cs_n,
    output logic o_ras_n,
    output logic o_cas_n,
    output logic o_we_n,
    output logic [2:0] o_ba,
    output logic [14:0] o_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_cke = 1'b1;
        {o_cs_n, o_ras_n, o_cas_n, o_we_n} = `PAT_NOP;
        o_ba = 3'h0;
        o_addr = 15'h0000;
    end
    // One command edge, then NOP; clock enable keeps its new level
    task automatic issue(input logic [3:0] pat, input logic [2:0] b, input logic [14:0] a, input logic ck);
        @(posedge i_clk_sys);
        #1;
        {o_cs_n, o_ras_n, o_cas_n, o_we_n} = pat;
        o_ba = b;
        o_addr = a;
        o_cke = ck;
        @(posedge i_clk_sys);
        #1;
        {o_cs_n, o_ras_n, o_cas_n, o_we_n} = `PAT_NOP;
        // Address is don't-care now, so it must not keep the last value
        o_ba = ~b;
        o_addr = ~a;
    endtask
endmodule
`default_nettype wire

// *** testbench/ddr2_command_decode_bank_state_test.sv ***
// Self-checking bench for the DDR2 command decoder
`default_nettype none
`include "ddr2_cmd_regs.vh"
module ddr2_command_decode_bank_state_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk_sys, i_arst_n, i_odt, i_ba2_used;
    wire cke, cs_n, ras_n, cas_n, we_n;
    wire [2:0] ba;
    wire [14:0] addr;
    logic [3:0] o_cmd;
    logic [2:0] o_bank;
    logic [14:0] o_addr;
    logic o_cmd_valid, o_auto_pre, o_power_down, o_self_refresh, o_odt_enable, o_illegal;
    logic [7:0] o_bank_idle, o_bank_active;
    logic [18:0] seen_ba;
    int failures, checks_done;
    ddr2_ctrl_model ctrl_u (.i_clk_sys(i_clk_sys), .o_cke(cke), .o_cs_n(cs_n), .o_ras_n(ras_n),
        .o_cas_n(cas_n), .o_we_n(we_n), .o_ba(ba), .o_addr(addr));
    ddr2_command_decode_bank_state dut_u (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_cke(cke),
        .i_cs_n(cs_n), .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n), .i_ba(ba), .i_addr(addr),
        .i_odt(i_odt), .i_ba2_used(i_ba2_used), .o_cmd(o_cmd), .o_cmd_valid(o_cmd_valid), .o_bank(o_bank),
        .o_addr(o_addr), .o_auto_pre(o_auto_pre), .o_power_down(o_power_down),
        .o_self_refresh(o_self_refresh), .o_odt_enable(o_odt_enable), .o_illegal(o_illegal),
        .o_bank_idle(o_bank_idle), .o_bank_active(o_bank_active));
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end
    task automatic stop_test;
        if (failures == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Decoded code lands three edges after the pins, the flag one edge later
    task automatic send(input logic [3:0] pat, input logic [2:0] b, input logic [14:0] a, input logic ck,
        input logic [3:0] ec, input logic ei);
        ctrl_u.issue(pat, b, a, ck);
        repeat (2) @(posedge i_clk_sys);
        #1;
        seen_ba = {o_auto_pre, o_bank, o_addr};
        chk(o_cmd, ec);
        chk(o_cmd_valid, 1'b1);
        @(posedge i_clk_sys);
        #1;
        chk(o_illegal, ei);
    endtask
    task automatic sc_bank_flow;
        send(`PAT_ACT, 3'h2, 15'h1234, 1'b1, `CMD_ACT, 1'b0);
        chk(seen_ba, {1'b0, 3'h2, 15'h1234});
        repeat (2) @(posedge i_clk_sys);
        #1;
        chk(o_bank_active, 8'h04);
        send(`PAT_RD, 3'h2, 15'h0010, 1'b1, `CMD_RD, 1'b0);
        send(`PAT_WR, 3'h2, 15'h0020, 1'b1, `CMD_WR, 1'b0);
        send(`PAT_RD, 3'h2, 15'h0430, 1'b1, `CMD_RDA, 1'b0);
        chk(seen_ba, {1'b1, 3'h2, 15'h0430});
        repeat (10) @(posedge i_clk_sys);
        #1;
        chk(o_bank_idle, 8'hff);
        send(`PAT_ACT, 3'h2, 15'h0001, 1'b1, `CMD_ACT, 1'b0);
        send(`PAT_WR, 3'h2, 15'h0400, 1'b1, `CMD_WRA, 1'b0);
        repeat (10) @(posedge i_clk_sys);
        send(`PAT_ACT, 3'h3, 15'h0002, 1'b1, `CMD_ACT, 1'b0);
        send(`PAT_PRE, 3'h3, 15'h0000, 1'b1, `CMD_PRE, 1'b0);
        send(`PAT_PRE, 3'h5, 15'h0400, 1'b1, `CMD_PREA, 1'b0);
        send(`PAT_MRS, 3'h1, 15'h0042, 1'b1, `CMD_MRS, 1'b0);
        send(`PAT_REF, 3'h0, 15'h0000, 1'b1, `CMD_REF, 1'b0);
        repeat (25) @(posedge i_clk_sys);
    endtask
    task automatic sc_refused;
        send(`PAT_RD, 3'h5, 15'h0000, 1'b1, `CMD_RD, 1'b1);
        send(`PAT_ACT, 3'h5, 15'h0000, 1'b1, `CMD_ACT, 1'b0);
        send(`PAT_ACT, 3'h5, 15'h0000, 1'b1, `CMD_ACT, 1'b1);
        send(`PAT_REF, 3'h0, 15'h0000, 1'b1, `CMD_REF, 1'b1);
        repeat (25) @(posedge i_clk_sys);
        send(`PAT_PRE, 3'h0, 15'h0400, 1'b1, `CMD_PREA, 1'b0);
    endtask
    task automatic sc_idle_cmds;
        send(4'hf, 3'h0, 15'h0000, 1'b1, `CMD_DES, 1'b0);
        send(`PAT_NOP, 3'h0, 15'h0000, 1'b1, `CMD_NOP, 1'b0);
        i_ba2_used = 1'b0;
        send(`PAT_ACT, 3'h6, 15'h0003, 1'b1, `CMD_ACT, 1'b0);
        chk(seen_ba, {1'b0, 3'h2, 15'h0003});
        i_ba2_used = 1'b1;
        send(`PAT_PRE, 3'h2, 15'h0000, 1'b1, `CMD_PRE, 1'b0);
    endtask
    task automatic sc_power;
        i_odt = 1'b1;
        send(`PAT_NOP, 3'h0, 15'h0000, 1'b0, `CMD_PDE, 1'b0);
        chk(o_power_down, 1'b1);
        send(`PAT_NOP, 3'h0, 15'h0000, 1'b1, `CMD_PDX, 1'b0);
        chk({o_power_down, o_odt_enable}, 2'b01);
        send(`PAT_REF, 3'h0, 15'h0000, 1'b0, `CMD_SRE, 1'b0);
        chk({o_self_refresh, o_odt_enable}, 2'b10);
        send(`PAT_NOP, 3'h0, 15'h0000, 1'b1, `CMD_SRX, 1'b0);
        send(`PAT_ACT, 3'h1, 15'h0000, 1'b1, `CMD_ACT, 1'b1);
        repeat (25) @(posedge i_clk_sys);
        send(`PAT_ACT, 3'h1, 15'h0000, 1'b1, `CMD_ACT, 1'b0);
        send(`PAT_PRE, 3'h0, 15'h0400, 1'b1, `CMD_PREA, 1'b0);
        i_odt = 1'b0;
    endtask
    initial begin
        i_arst_n = 1'b0;
        i_odt = 1'b0;
        i_ba2_used = 1'b1;
        failures = 0;
        checks_done = 0;
        repeat (8) @(posedge i_clk_sys);
        #1;
        chk(o_bank_idle, 8'hff);
        i_arst_n = 1'b1;
        repeat (6) @(posedge i_clk_sys);
        sc_bank_flow;
        sc_refused;
        sc_idle_cmds;
        sc_power;
        stop_test;
    end
    // Whole run is well under a thousand cycles
    initial begin
        #50000;
        failures++;
        stop_test;
    end
endmodule
`default_nettype wire
